// >>> dv/acrz_checker.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Port-level checks of the first setup register block.
// ************************************************************
module acrz_checker
	import acrz_pkg::*;
#(
	parameter int CONV_CYC = CONV_CYCLES,
	parameter int PULSE_CYC = READY_PULSE_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic host_wr_n,
	input wire logic host_rd_n,
	input wire logic [DATA_W-1:0] host_data_in,
	input wire logic [DATA_W-1:0] host_data_out,
	input wire logic host_data_oe,
	input wire logic ref_external,
	input wire logic converter_enable,
	input wire logic hold_all,
	input wire logic convert_strobe,
	input wire logic [1:0] check_voltage_sel,
	input wire logic samples_ready_flag_n,
	input wire logic [REG_W-1:0] setup_value
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_ref; ref_external == setup_value[BIT_REF_EXT]; endproperty
	property p_run; converter_enable == !setup_value[2]; endproperty
	property p_test; check_voltage_sel == setup_value[BIT_TEST_HI:BIT_TEST_LO]; endproperty
	property p_quiet; $fell(samples_ready_flag_n) |-> $past(check_voltage_sel) == TEST_NONE;
	endproperty
	property p_pulse; $fell(samples_ready_flag_n) |=> !samples_ready_flag_n ##1 samples_ready_flag_n;
	endproperty
	property p_hold; hold_all |-> convert_strobe && setup_value[BIT_SINGLE] ##1 !hold_all;
	endproperty
	// Each channel needs its full convert count before the next may start.
	property p_gap; convert_strobe |=> !convert_strobe [*4]; endproperty
	property p_oe; $rose(host_data_oe) |-> !host_rd_n && $past(!host_rd_n, 3); endproperty
	property p_wr; $changed(setup_value) |-> host_wr_n && $past(host_wr_n, 3)
		&& $past(host_data_in[BIT_SEL_HI:BIT_SEL_LO], 3) == SETUP_A_SELECT; endproperty
	a_ref: assert property (p_ref) else $error("reference select mismatch");
	a_run: assert property (p_run) else $error("converter enable mismatch");
	a_test: assert property (p_test) else $error("test select mismatch");
	a_quiet: assert property (p_quiet) else $error("ready pulse in test mode");
	a_pulse: assert property (p_pulse) else $error("ready pulse length wrong");
	a_hold: assert property (p_hold) else $error("hold pulse wrong");
	a_gap: assert property (p_gap) else $error("convert strobes too close");
	a_oe: assert property (p_oe) else $error("drive without read strobe");
	a_wr: assert property (p_wr) else $error("setup change without write");
	c_ready: cover property ($fell(samples_ready_flag_n));
	c_hold: cover property (hold_all);
	c_read: cover property ($rose(host_data_oe));
endmodule

bind acrz_top acrz_checker #(.CONV_CYC(CONV_CYC), .PULSE_CYC(PULSE_CYC)) u_acrz_checker (
	.clk, .sys_rst, .host_wr_n, .host_rd_n, .host_data_in, .host_data_out, .host_data_oe,
	.ref_external, .converter_enable, .hold_all, .convert_strobe, .check_voltage_sel,
	.samples_ready_flag_n, .setup_value
);
`default_nettype wire

// >>> dv/acrz_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module acrz_host_model
	import acrz_pkg::*;
(
	input wire logic clk,
	output var logic host_wr_n,
	output var logic host_rd_n,
	output var logic [DATA_W-1:0] host_data_in,
	input wire logic [DATA_W-1:0] host_data_out,
	input wire logic host_data_oe
);
	initial begin
		host_wr_n = 1'b1;
		host_rd_n = 1'b1;
		host_data_in = 12'hAAA;
	end
	// The caller puts the select bits of the wanted register on top.
	task automatic write_word(input logic [DATA_W-1:0] w);
		host_data_in = w;
		host_wr_n = 1'b0;
		repeat (4) @(negedge clk);
		host_wr_n = 1'b1;
		repeat (6) @(negedge clk);
		// A released bus keeps no value, so the inverse shows up.
		host_data_in = ~w;
		@(negedge clk);
	endtask
	task automatic read_word(output logic [DATA_W-1:0] d, output logic oe);
		host_rd_n = 1'b0;
		repeat (6) @(negedge clk);
		d = host_data_out;
		oe = host_data_oe;
		host_rd_n = 1'b1;
		repeat (6) @(negedge clk);
	endtask
endmodule
`default_nettype wire

// >>> dv/adc_config_register_zero_bench.sv
`timescale 1ns/1ps
`default_nettype none

module adc_config_register_zero_bench;
	import acrz_pkg::*;
	logic clk, sys_rst, host_wr_n, host_rd_n, host_data_oe, conversion_pace_clock, rd_oe;
	logic [DATA_W-1:0] host_data_in, host_data_out, sample_in, rd_val;
	logic [TRIG_W-1:0] trigger_level;
	logic ref_external, converter_enable, hold_all, convert_strobe, samples_ready_flag_n;
	logic buffer_overflow;
	logic [2:0] active_channel;
	logic [1:0] check_voltage_sel;
	logic [REG_W-1:0] setup_value;
	logic [DATA_W-1:0] s_q[$];
	logic [DATA_W-1:0] keep_q[$];
	int err_total, compares, ready_cnt, hold_cnt, strobe_cnt, seed, r0, h0, st0;
	acrz_top u_acrz_top (.clk, .sys_rst, .host_wr_n, .host_rd_n, .host_data_in,
		.host_data_out, .host_data_oe, .conversion_pace_clock, .trigger_level, .sample_in,
		.ref_external, .converter_enable, .hold_all, .convert_strobe, .active_channel,
		.check_voltage_sel, .samples_ready_flag_n, .buffer_overflow, .setup_value);
	acrz_host_model u_acrz_host_model (.clk, .host_wr_n, .host_rd_n, .host_data_in,
		.host_data_out, .host_data_oe);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(negedge samples_ready_flag_n) ready_cnt++;
	always @(posedge hold_all) hold_cnt++;
	always @(posedge convert_strobe) strobe_cnt++;
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("mismatches=%0d comparisons=%0d", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	function automatic logic [DATA_W-1:0] test_code(input logic [1:0] t);
		return (t == 2'h1) ? TEST_CODE_HIGH : (t == 2'h2) ? TEST_CODE_MID : TEST_CODE_LOW;
	endfunction
	task automatic setup(input logic [REG_W-1:0] v, input logic [TRIG_W-1:0] trig);
		trigger_level = trig;
		u_acrz_host_model.write_word({SETUP_A_SELECT, v});
		r0 = ready_cnt;
		s_q.delete();
	endtask
	// The sample is held until the next start, so the converter latches a known value.
	task automatic pace(input int n);
		sample_in = 12'($random(seed));
		s_q.push_back(sample_in);
		conversion_pace_clock = 1'b0;
		repeat (4) @(negedge clk);
		conversion_pace_clock = 1'b1;
		repeat (n) @(negedge clk);
	endtask
	task automatic read_chk(input logic [DATA_W-1:0] exp);
		u_acrz_host_model.read_word(rd_val, rd_oe);
		chk(rd_val, exp);
		chk(12'(rd_oe), 12'h1);
	endtask
	initial begin
		#240000;
		err_total++;
		close_out;
	end
	initial begin
		sys_rst = 1'b1;
		conversion_pace_clock = 1'b1;
		trigger_level = 5'h01;
		sample_in = 12'h000;
		seed = 32'he5d5;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		chk(12'(setup_value), 12'(SETUP_A_RESET));
		chk({7'h00, buffer_overflow, ref_external, converter_enable, samples_ready_flag_n,
			host_data_oe}, 12'h006);
		repeat (4) @(negedge clk);
		for (int i = 1; i < 4; i++) begin
			u_acrz_host_model.write_word({2'(i), 10'h3FF});
			chk(12'(setup_value), 12'(SETUP_A_RESET));
		end
		for (int i = 0; i < 6; i++) begin
			setup((i == 0) ? 10'h3FF : 10'($random(seed)), 5'h01);
			chk(12'(setup_value[REG_W-1:0]), 12'(u_acrz_host_model.host_data_in[9:0] ^ 10'h3FF));
			chk({9'h000, check_voltage_sel, ref_external}, {9'h000, setup_value[9:8], setup_value[0]});
			chk(12'(converter_enable), 12'(!setup_value[2]));
		end
		setup(10'h000, 5'h02);
		pace(16);
		pace(16);
		chk(12'(ready_cnt - r0), 12'h001);
		read_chk(s_q[0]);
		read_chk(s_q[1]);
		setup(10'h09A, 5'h04);
		h0 = hold_cnt;
		st0 = strobe_cnt;
		pace(40);
		chk(12'(hold_cnt - h0), 12'h001);
		chk(12'(strobe_cnt - st0), 12'h004);
		chk(12'(ready_cnt - r0), 12'h001);
		repeat (4) read_chk(s_q[0]);
		// Two words are stored before sleep; the edge seen while asleep must add none.
		setup(10'h000, 5'h02);
		pace(16);
		pace(16);
		keep_q = s_q;
		setup(10'h004, 5'h02);
		pace(16);
		chk(12'(ready_cnt - r0), 12'h000);
		read_chk(keep_q[0]);
		read_chk(keep_q[1]);
		for (int t = 1; t < 4; t++) begin
			setup({2'(t), 8'h00}, 5'h01);
			pace(16);
			chk(12'(ready_cnt - r0), 12'h000);
			read_chk(test_code(2'(t)));
		end
		setup(10'h028, 5'h01);
		chk(12'(active_channel), 12'(CH_B_DIFF));
		setup(10'h000, 5'h01);
		chk(12'(active_channel), 12'(CH_A_POS));
		pace(16);
		chk(12'(ready_cnt - r0), 12'h001);
		read_chk(s_q[0]);
		close_out;
	end
endmodule
`default_nettype wire

// >>> src/acrz_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Three-stage pin synchroniser with agreement filter.
// ************************************************************
module acrz_pin_sync #(
	parameter int W = 3,
	parameter logic [W-1:0] INIT = '1
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] level_reg;
	logic [W-1:0] level_next;
	logic [W-1:0] prev_reg;

	// A change counts only once the second and third stages agree.
	assign level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_reg <= INIT;
			s2_reg <= INIT;
			s3_reg <= INIT;
			level_reg <= INIT;
			prev_reg <= INIT;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level_reg <= level_next;
			prev_reg <= level_reg;
		end
	end

	assign level = level_reg;
	assign rise = level_reg & ~prev_reg;
	assign fall = ~level_reg & prev_reg;
endmodule

`default_nettype wire

// >>> src/acrz_pkg.sv
package acrz_pkg;

	// ************************************************************
	// Widths and field positions of the first setup register.
	// ************************************************************
	localparam int DATA_W = 12;
	localparam int REG_W = 10;
	localparam int TRIG_W = 5;
	localparam int BIT_REF_EXT = 0;
	localparam int BIT_SINGLE = 1;
	localparam int BIT_PD = 2;
	localparam int BIT_CHSEL_LO = 3;
	localparam int BIT_CHSEL_HI = 4;
	localparam int BIT_DIFF_LO = 5;
	localparam int BIT_DIFF_HI = 6;
	localparam int BIT_SCAN = 7;
	localparam int BIT_TEST_LO = 8;
	localparam int BIT_TEST_HI = 9;
	localparam int BIT_SEL_LO = 10;
	localparam int BIT_SEL_HI = 11;
	localparam logic [1:0] SETUP_A_SELECT = 2'h0;
	localparam logic [REG_W-1:0] SETUP_A_RESET = 10'h020;
	localparam logic [1:0] TEST_NONE = 2'h0;

	// ************************************************************
	// Sample buffer and timing.
	// ************************************************************
	localparam int FIFO_DEPTH = 16;
	localparam int CLK_PERIOD_NS = 40;
	localparam int CONV_TIME_NS = 160;
	localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READY_PULSE_NS = 80;
	localparam int READY_PULSE_CYCLES = READY_PULSE_NS / CLK_PERIOD_NS;
	localparam logic [DATA_W-1:0] TEST_CODE_HIGH = 12'hFFF;
	localparam logic [DATA_W-1:0] TEST_CODE_MID = 12'h800;
	localparam logic [DATA_W-1:0] TEST_CODE_LOW = 12'h000;

	// ************************************************************
	// Physical input codes.
	// ************************************************************
	localparam logic [2:0] CH_A_POS = 3'h0;
	localparam logic [2:0] CH_A_NEG = 3'h1;
	localparam logic [2:0] CH_B_POS = 3'h2;
	localparam logic [2:0] CH_B_NEG = 3'h3;
	localparam logic [2:0] CH_A_DIFF = 3'h4;
	localparam logic [2:0] CH_B_DIFF = 3'h5;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CONVERT,
		ST_STORE
	} acrz_state_t;

endpackage

// >>> src/acrz_top.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// [R01] Position 0 low picks internal reference, high picks external reference.
// [R02] Position 1 low selects continuous conversion paced by the pace clock.
// [R03] Continuous mode stores one new sample per falling pace-clock edge.
// [R04] Position 1 high turns the pace pin into a host-pulsed start input.
// [R05] Start falling edge holds all inputs together, then converts selected channels in turn.
// [R06] Data-available output asserts once the buffer trigger condition is met.
// [R07] Position 2 low runs the converter; high powers it down.
// [R08] Power-down still allows register writes, output reads and buffer readout.
// [R09] Bits 3 and 4 pick the single input channel; reset zero.
// [R10] Bits 5 and 6 give differential count; reset bit5 one, bit6 zero.
// [R11] Bit 7 enables automatic multi-input scanning; reset zero.
// [R12] Bits 8 and 9 select normal or one of three test voltages.
// [R13] Data-available stays inactive whenever any test mode is selected.
// [R14] Host reads test results without waiting for data-available.
// [R15] Host repeats full initialization to leave test mode.
// [R16] Host writes this register with data bits 11 and 10 both zero.
// [R17] Trigger met when samples written since last trigger equal trigger level.
// [R18] Data-available is an active-low pulse; host then reads trigger-level samples.
// [R19] Reset loads all fields zero except differential count low bit one.
module acrz_top
	import acrz_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH,
	parameter int CONV_CYC = CONV_CYCLES,
	parameter int PULSE_CYC = READY_PULSE_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic host_wr_n,
	input wire logic host_rd_n,
	input wire logic [DATA_W-1:0] host_data_in,
	output logic [DATA_W-1:0] host_data_out,
	output logic host_data_oe,
	input wire logic conversion_pace_clock,
	input wire logic [TRIG_W-1:0] trigger_level,
	input wire logic [DATA_W-1:0] sample_in,
	output logic ref_external,
	output logic converter_enable,
	output logic hold_all,
	output logic convert_strobe,
	output logic [2:0] active_channel,
	output logic [1:0] check_voltage_sel,
	output logic samples_ready_flag_n,
	output logic buffer_overflow,
	output logic [REG_W-1:0] setup_value
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(CONV_CYC + 1);
	localparam int QW = $clog2(PULSE_CYC + 1);

	// ************************************************************
	// Scan sequence decoding.
	// ************************************************************
	function automatic logic [2:0] seq_len(input logic [REG_W-1:0] cfg);
		logic [4:0] sel;
		sel = {cfg[BIT_SCAN], cfg[BIT_DIFF_HI], cfg[BIT_DIFF_LO], cfg[BIT_CHSEL_HI],
			cfg[BIT_CHSEL_LO]};
		case (sel)
			5'h11: seq_len = 3'h2;
			5'h12: seq_len = 3'h3;
			5'h13: seq_len = 3'h4;
			5'h15: seq_len = 3'h2;
			5'h16: seq_len = 3'h3;
			5'h19: seq_len = 3'h2;
			default: seq_len = 3'h1;
		endcase
	endfunction

	function automatic logic [2:0] seq_chan(input logic [REG_W-1:0] cfg, input logic [1:0] idx);
		logic [4:0] sel;
		sel = {cfg[BIT_SCAN], cfg[BIT_DIFF_HI], cfg[BIT_DIFF_LO], cfg[BIT_CHSEL_HI],
			cfg[BIT_CHSEL_LO]};
		case (sel)
			5'h00, 5'h01, 5'h02, 5'h03: seq_chan = {1'b0, sel[1:0]};
			5'h04: seq_chan = CH_A_DIFF;
			5'h05: seq_chan = CH_B_DIFF;
			5'h11, 5'h12, 5'h13: seq_chan = {1'b0, idx};
			5'h15: seq_chan = (idx == 2'h0) ? CH_A_POS : CH_B_DIFF;
			5'h16: seq_chan = (idx == 2'h2) ? CH_B_DIFF : {1'b0, idx};
			5'h19: seq_chan = (idx == 2'h0) ? CH_A_DIFF : CH_B_DIFF;
			default: seq_chan = CH_A_POS;
		endcase
	endfunction

	// ************************************************************
	// Pin synchronisers.
	// ************************************************************
	logic [2:0] pin_level;
	logic [2:0] pin_rise;
	logic [2:0] pin_fall;

	acrz_pin_sync #(
		.W(3),
		.INIT(3'h7)
	) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin_in({conversion_pace_clock, host_rd_n, host_wr_n}),
		.level(pin_level),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	// ************************************************************
	// Setup register write.
	// ************************************************************
	logic [REG_W-1:0] converter_setup_register_a_reg;
	wire reg_select_lo = host_data_in[BIT_SEL_LO];
	wire reg_select_hi = host_data_in[BIT_SEL_HI];
	// The host must hold its data until the write strobe has been seen through the synchroniser.
	wire setup_a_hit = pin_rise[0] && ({reg_select_hi, reg_select_lo} == SETUP_A_SELECT); // [R16]

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			converter_setup_register_a_reg <= SETUP_A_RESET; // [R19] [R09] [R10] [R11] [R12]
		end else if (setup_a_hit) begin
			converter_setup_register_a_reg <= host_data_in[REG_W-1:0]; // [R08]
		end
	end

	wire [REG_W-1:0] cfg = converter_setup_register_a_reg;
	wire single_mode = cfg[BIT_SINGLE];
	wire power_down_ctl = cfg[BIT_PD];
	wire [1:0] check_sel = {cfg[BIT_TEST_HI], cfg[BIT_TEST_LO]};
	wire test_active = (check_sel != TEST_NONE);
	wire [2:0] cur_len = seq_len(cfg); // [R09] [R10] [R11]

	assign setup_value = converter_setup_register_a_reg;
	assign ref_external = cfg[BIT_REF_EXT]; // [R01]
	assign converter_enable = ~power_down_ctl; // [R07]
	assign check_voltage_sel = check_sel; // [R12]

	// ************************************************************
	// Conversion sequencer.
	// ************************************************************
	acrz_state_t state_reg;
	acrz_state_t state_next;
	logic [CW-1:0] cyc_reg;
	logic [1:0] idx_reg;
	logic [1:0] idx_next;
	logic hold_reg;
	logic [2:0] chan_reg;
	logic [DATA_W-1:0] result_reg;

	// Edges are dropped while a conversion is under way or the converter sleeps.
	wire start_event = pin_fall[2] && !power_down_ctl && (state_reg == ST_IDLE); // [R03] [R05]
	wire conv_done = (cyc_reg == CW'(CONV_CYC - 1));
	wire idx_wrap = ({1'b0, idx_reg} + 3'h1 >= cur_len);
	wire [1:0] idx_inc = idx_wrap ? 2'h0 : idx_reg + 2'h1;
	wire push = (state_reg == ST_STORE);
	wire [DATA_W-1:0] test_code = (check_sel == 2'h1) ? TEST_CODE_HIGH :
		(check_sel == 2'h2) ? TEST_CODE_MID : TEST_CODE_LOW;
	wire [DATA_W-1:0] store_value = test_active ? test_code : result_reg; // [R12]

	always_comb begin
		state_next = state_reg;
		idx_next = idx_reg;
		case (state_reg)
			ST_IDLE: begin
				if (start_event) begin
					state_next = ST_CONVERT;
					idx_next = single_mode ? 2'h0 : idx_reg; // [R04] [R02]
				end else if (setup_a_hit) begin
					idx_next = 2'h0;
				end
			end
			ST_CONVERT: begin
				if (conv_done) begin
					state_next = ST_STORE;
				end
			end
			ST_STORE: begin
				idx_next = idx_inc;
				if (single_mode && !idx_wrap) begin
					state_next = ST_CONVERT; // [R05]
				end else begin
					state_next = ST_IDLE; // [R03]
				end
			end
			default: begin
				state_next = ST_IDLE;
				idx_next = 2'h0;
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
			idx_reg <= 2'h0;
			cyc_reg <= '0;
			hold_reg <= 1'b0;
			chan_reg <= CH_A_POS;
			result_reg <= '0;
		end else begin
			state_reg <= state_next;
			idx_reg <= idx_next;
			cyc_reg <= (state_reg == ST_CONVERT && !conv_done) ? cyc_reg + CW'(1) : '0;
			hold_reg <= start_event && single_mode; // [R05]
			chan_reg <= seq_chan(cfg, idx_next);
			if (state_reg == ST_CONVERT && conv_done) begin
				result_reg <= sample_in;
			end
		end
	end

	assign hold_all = hold_reg;
	assign active_channel = chan_reg;
	assign convert_strobe = (state_reg == ST_CONVERT) && (cyc_reg == '0);

	// ************************************************************
	// Circular sample buffer.
	// ************************************************************
	logic [DATA_W-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [PW:0] count_reg;
	logic overflow_reg;
	logic [DATA_W-1:0] out_reg;

	wire full = (count_reg == (PW+1)'(DEPTH));
	wire empty = (count_reg == '0);
	// Readout stays live in power-down, so a sleeping converter can still be drained.
	wire pop = pin_rise[1] && !empty; // [R08]
	// A full buffer overwrites its oldest entry rather than stall the converter.
	wire drop_oldest = push && full && !pop;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= store_value; // [R03]
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			overflow_reg <= 1'b0;
			out_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + PW'(1);
			end
			if (pop || drop_oldest) begin
				rd_ptr_reg <= rd_ptr_reg + PW'(1);
			end
			if (push && !pop && !full) begin
				count_reg <= count_reg + (PW+1)'(1);
			end else if (pop && !push) begin
				count_reg <= count_reg - (PW+1)'(1);
			end
			if (drop_oldest) begin
				overflow_reg <= 1'b1;
			end else if (setup_a_hit) begin
				overflow_reg <= 1'b0;
			end
			if (pin_fall[1]) begin
				out_reg <= mem[rd_ptr_reg];
			end
		end
	end

	assign host_data_out = out_reg;
	assign host_data_oe = ~pin_level[1];
	assign buffer_overflow = overflow_reg;

	// ************************************************************
	// Data-available pulse.
	// ************************************************************
	logic [TRIG_W-1:0] trig_cnt_reg;
	logic [QW-1:0] pulse_reg;
	logic ready_n_reg;

	wire [TRIG_W-1:0] level_eff = (trigger_level == '0) ? TRIG_W'(1) : trigger_level;
	wire trig_hit = push && (trig_cnt_reg + TRIG_W'(1) >= level_eff); // [R17]

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			trig_cnt_reg <= '0;
			pulse_reg <= '0;
			ready_n_reg <= 1'b1;
		end else begin
			if (test_active || trig_hit) begin
				trig_cnt_reg <= '0;
			end else if (push) begin
				trig_cnt_reg <= trig_cnt_reg + TRIG_W'(1);
			end
			if (test_active) begin
				pulse_reg <= '0; // [R13]
			end else if (trig_hit) begin
				pulse_reg <= QW'(PULSE_CYC); // [R06] [R18]
			end else if (pulse_reg != '0) begin
				pulse_reg <= pulse_reg - QW'(1);
			end
			ready_n_reg <= test_active || !(trig_hit || pulse_reg > QW'(1)); // [R18]
		end
	end

	assign samples_ready_flag_n = ready_n_reg;
endmodule

`default_nettype wire
